// ---- hdl/reset_cause_and_system_options.sv ----
// Reset sequencer, reset-cause status, debug force reset, write-once options
// Function
// - Reset sets active source flags, clears others
// - Debug forced reset leaves all flags clear
// - Status write restarts watchdog, flags unchanged
// - Power-on sets power-on and low-voltage flags
// - Low-voltage keeps power-on flag; bit0 zero
// - Low reset pin sets pin flag
// - Watchdog reset sets its flag, gated by enable
// - Bad opcode, disabled halt/debug entry reset
// - Gap address access resets, sets flag
// - Register-area holes never cause address reset
// - Clock module request sets its flag
// - Low-voltage reset needs enables; halt gating
// - Force register debug-writable only, reads zero
// - Debug writing force bit causes reset
// - Options readable, write-once, bits 4,3,2,0 zero
// - Watchdog enable defaults one, gates timeout
// - Timeout select: 2^13 or 2^18 cycles
// - Halt enable defaults zero; halt illegal then
// - Debug pin enable, back to debug on reset
`timescale 1ns/1ps
`default_nettype none
module reset_cause_and_system_options
  import reset_ctl_pkg::*;
#(
  parameter int unsigned WD_SHORT = WD_SHORT_CYCLES,
  parameter int unsigned WD_LONG  = WD_LONG_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [15:0] cpu_addr,
  input  wire logic        cpu_rd,
  input  wire logic        cpu_wr,
  input  wire logic [7:0]  cpu_wdata,
  output logic      [7:0]  cpu_rdata,
  input  wire logic        dbg_wr,
  input  wire logic [15:0] dbg_addr,
  input  wire logic [7:0]  dbg_wdata,
  input  wire logic        reset_pin_n,
  input  wire logic        opcode_unimpl,
  input  wire logic        halt_exec,
  input  wire logic        enter_debug_exec,
  input  wire logic        debug_mode_enable,
  input  wire logic        clock_module_reset_req,
  input  wire logic        supply_low,
  input  wire logic        supply_detect_enable,
  input  wire logic        supply_detect_reset_enable,
  input  wire logic        supply_detect_in_halt_enable,
  input  wire logic        in_halt_mode,
  output logic             system_reset,
  output logic [7:0]       reset_cause_status,
  output logic             watchdog_enable,
  output logic             watchdog_timeout_select,
  output logic             halt_mode_enable,
  output logic             debug_pin_enable
);

  // ==========================================================================
  // Declarations
  trip_if tif ();

  seq_state_t  state_ff;
  seq_state_t  nxt_state;
  logic [3:0]  hold_cnt_ff;
  logic [3:0]  nxt_hold_cnt;
  logic [7:0]  cause_ff;
  logic [7:0]  nxt_cause;
  logic [7:0]  opts_ff;
  logic [7:0]  nxt_opts;
  logic        opts_locked_ff;
  logic        nxt_opts_locked;
  logic [7:0]  rdata_ff;
  logic [7:0]  nxt_rdata;

  logic        run;
  logic        pin_req;
  logic        wd_req;
  logic        op_req;
  logic        ad_req;
  logic        clk_req;
  logic        lvd_req;
  logic        force_req;
  logic        any_req;
  logic        status_wr;
  logic        opts_wr;
  logic [7:0]  captured;

  // ==========================================================================
  // Helpers
  assign run       = (state_ff == ST_RUN);
  // CPU is held in reset during HOLD, so its writes and gap accesses are ignored then; reads still load the read data
  assign status_wr = run && cpu_wr && (cpu_addr == STATUS_ADDR);
  assign opts_wr   = run && cpu_wr && (cpu_addr == OPTIONS_ADDR);

  // ==========================================================================
  // Sub-blocks
  assign tif.wd_restart = status_wr;
  assign tif.wd_hold    = !run;
  assign tif.wd_enable  = opts_ff[B_WDE];
  assign tif.wd_long    = opts_ff[B_WDT];
  assign tif.addr       = cpu_addr;
  assign tif.access     = run && (cpu_rd || cpu_wr);

  watchdog_timer #(
    .SHORT_CYCLES (WD_SHORT),
    .LONG_CYCLES  (WD_LONG)
  ) u_wdog (
    .sys_clk (sys_clk),
    .rst     (rst),
    .tif     (tif.wdog)
  );

  addr_gap_check u_gap (
    .tif (tif.chk)
  );

  // ==========================================================================
  // Reset sources
  assign pin_req = !reset_pin_n;
  assign wd_req  = tif.wd_trip;
  assign ad_req  = tif.addr_trip;
  assign clk_req = clock_module_reset_req;
  // Halt is illegal while halt mode is off, debug entry likewise
  assign op_req  = opcode_unimpl ||
                   (halt_exec && !opts_ff[B_HALT]) ||
                   (enter_debug_exec && !debug_mode_enable);
  // Detector stops in halt mode unless told to keep running
  assign lvd_req = supply_low && supply_detect_enable &&
                   supply_detect_reset_enable &&
                   (!in_halt_mode || supply_detect_in_halt_enable);
  // Only the debug port reaches the force bit; CPU writes go nowhere
  assign force_req = dbg_wr && (dbg_addr == FORCE_ADDR) &&
                     dbg_wdata[B_FORCE];
  assign any_req = pin_req || wd_req || op_req || ad_req ||
                   clk_req || lvd_req || force_req;

  // ==========================================================================
  // Cause capture: a low-voltage event owns the flags, power-on kept
  always_comb begin
    captured = 8'h00;
    if (lvd_req) begin
      captured[B_POR] = cause_ff[B_POR];
      captured[B_LVD] = 1'b1;
    end else begin
      captured[B_PIN] = pin_req;
      captured[B_WD]  = wd_req;
      captured[B_OP]  = op_req;
      captured[B_AD]  = ad_req;
      captured[B_CLK] = clk_req;
    end
    // A forced reset adds no flag of its own
  end

  // ==========================================================================
  // Sequencer: a request stretches system_reset to at least the hold time
  always_comb begin
    nxt_state    = state_ff;
    nxt_hold_cnt = hold_cnt_ff;
    nxt_cause    = cause_ff;
    case (state_ff)
      ST_RUN: begin
        if (any_req) begin
          nxt_state    = ST_HOLD;
          nxt_hold_cnt = HOLD_LOAD;
          nxt_cause    = captured;
        end
      end
      ST_HOLD: begin
        if (any_req) begin
          // A source that stays active keeps the reset going
          nxt_hold_cnt = HOLD_LOAD;
          nxt_cause    = captured;
        end else if (hold_cnt_ff == 4'h0) begin
          nxt_state = ST_RUN;
        end else begin
          nxt_hold_cnt = hold_cnt_ff - 4'h1;
        end
      end
      default: begin
        nxt_state    = ST_HOLD;
        nxt_hold_cnt = HOLD_LOAD;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_ff    <= ST_HOLD;
      hold_cnt_ff <= HOLD_LOAD;
      cause_ff    <= STATUS_POR_VALUE;
    end else begin
      state_ff    <= nxt_state;
      hold_cnt_ff <= nxt_hold_cnt;
      cause_ff    <= nxt_cause;
    end
  end

  // ==========================================================================
  // Write-once options, reloaded on every reset
  always_comb begin
    nxt_opts        = opts_ff;
    nxt_opts_locked = opts_locked_ff;
    if (!run) begin
      nxt_opts        = OPTIONS_RESET;
      nxt_opts_locked = 1'b0;
    end else if (opts_wr && !opts_locked_ff) begin
      nxt_opts        = cpu_wdata & OPTIONS_MASK;
      nxt_opts_locked = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      opts_ff        <= OPTIONS_RESET;
      opts_locked_ff <= 1'b0;
    end else begin
      opts_ff        <= nxt_opts;
      opts_locked_ff <= nxt_opts_locked;
    end
  end

  // ==========================================================================
  // Read data, registered one cycle after the strobe
  always_comb begin
    nxt_rdata = rdata_ff;
    if (cpu_rd) begin
      case (cpu_addr)
        STATUS_ADDR:  nxt_rdata = cause_ff;
        FORCE_ADDR:   nxt_rdata = FORCE_READ;
        OPTIONS_ADDR: nxt_rdata = opts_ff;
        default:      nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ==========================================================================
  // Outputs
  assign cpu_rdata               = rdata_ff;
  assign system_reset            = state_ff[1];
  assign reset_cause_status      = cause_ff;
  assign watchdog_enable         = opts_ff[B_WDE];
  assign watchdog_timeout_select = opts_ff[B_WDT];
  assign halt_mode_enable        = opts_ff[B_HALT];
  assign debug_pin_enable        = opts_ff[B_DBGP];

  // ==========================================================================
  // Checks
  a_force_clear: assert property (
    @(posedge sys_clk) disable iff (rst)
    (run && force_req && !pin_req && !wd_req && !op_req && !ad_req &&
     !clk_req && !lvd_req) |=> (cause_ff == 8'h00) && system_reset)
    else $error("forced reset left a cause flag set");

  a_status_write: assert property (
    @(posedge sys_clk) disable iff (rst)
    (status_wr && !any_req) |=> $stable(cause_ff))
    else $error("status write changed cause flags");

  a_pin_flag: assert property (
    @(posedge sys_clk) disable iff (rst)
    (run && pin_req && !lvd_req) |=> cause_ff[B_PIN] && system_reset)
    else $error("pin reset did not set pin flag");

  a_lvd_keeps_por: assert property (
    @(posedge sys_clk) disable iff (rst)
    (run && lvd_req) |=> cause_ff[B_LVD] &&
      (cause_ff[B_POR] == $past(cause_ff[B_POR])) &&
      (cause_ff[6:2] == 5'h00))
    else $error("low-voltage capture wrong");

  a_bit0_zero: assert property (
    @(posedge sys_clk) disable iff (rst)
    !cause_ff[0])
    else $error("status bit 0 not zero");

  a_halt_illegal: assert property (
    @(posedge sys_clk) disable iff (rst)
    (run && halt_exec && !halt_mode_enable && !lvd_req)
      |=> cause_ff[B_OP])
    else $error("disabled halt did not reset");

  a_gap_access: assert property (
    @(posedge sys_clk) disable iff (rst)
    (run && cpu_rd && (cpu_addr == GAP2_LO) && !lvd_req)
      |=> cause_ff[B_AD] && system_reset)
    else $error("gap access did not reset");

  a_opts_once: assert property (
    @(posedge sys_clk) disable iff (rst)
    (run && opts_locked_ff && opts_wr && !any_req) |=> $stable(opts_ff))
    else $error("second options write took effect");

  a_opts_reload: assert property (
    @(posedge sys_clk) disable iff (rst)
    $fell(system_reset) |-> (opts_ff == OPTIONS_RESET) &&
      !opts_locked_ff)
    else $error("options not at defaults after reset");

  a_reset_length: assert property (
    @(posedge sys_clk) disable iff (rst)
    $rose(system_reset) |-> system_reset [*8])
    else $error("reset pulse shorter than hold time");

  a_flags_hold: assert property (
    @(posedge sys_clk) disable iff (rst)
    (run && !any_req) |=> $stable(cause_ff))
    else $error("cause flags moved without a reset");

endmodule
`default_nettype wire

// ---- hdl/reset_ctl_pkg.sv ----
// Constants, field positions and types of the reset-cause and options block
package reset_ctl_pkg;

  // ==========================================================================
  // Register addresses on the CPU and debug ports
  localparam logic [15:0] STATUS_ADDR  = 16'h1800;
  localparam logic [15:0] FORCE_ADDR   = 16'h1801;
  localparam logic [15:0] OPTIONS_ADDR = 16'h1802;

  // ==========================================================================
  // Illegal address gaps
  localparam logic [15:0] GAP1_LO = 16'h0880;
  localparam logic [15:0] GAP1_HI = 16'h17ff;
  localparam logic [15:0] GAP2_LO = 16'h182c;
  localparam logic [15:0] GAP2_HI = 16'hbfff;

  // ==========================================================================
  // Reset-cause status fields
  localparam int B_POR = 7;
  localparam int B_PIN = 6;
  localparam int B_WD  = 5;
  localparam int B_OP  = 4;
  localparam int B_AD  = 3;
  localparam int B_CLK = 2;
  localparam int B_LVD = 1;
  localparam logic [7:0] STATUS_POR_VALUE = 8'h82;

  // ==========================================================================
  // Options fields and force-reset field
  localparam int B_WDE   = 7;
  localparam int B_WDT   = 6;
  localparam int B_HALT  = 5;
  localparam int B_DBGP  = 1;
  localparam int B_FORCE = 0;
  localparam logic [7:0] OPTIONS_RESET = 8'hc2;
  localparam logic [7:0] OPTIONS_MASK  = 8'he2;
  localparam logic [7:0] FORCE_READ    = 8'h00;

  // ==========================================================================
  // Cycle counts
  localparam int          RESET_HOLD_CYCLES = 8;
  localparam logic [3:0]  HOLD_LOAD         = 4'(RESET_HOLD_CYCLES - 1);
  localparam int unsigned WD_SHORT_CYCLES   = 2 ** 13;
  localparam int unsigned WD_LONG_CYCLES    = 2 ** 18;
  localparam int          WD_CNT_W          = 18;

  // ==========================================================================
  // Sequencer states
  typedef enum logic [1:0] {
    ST_RUN  = 2'b01,
    ST_HOLD = 2'b10
  } seq_state_t;

endpackage

// ---- hdl/trip_if.sv ----
// Interface between the sequencer, the watchdog and the address checker
`timescale 1ns/1ps
`default_nettype none
interface trip_if;
  logic        wd_restart;
  logic        wd_hold;
  logic        wd_enable;
  logic        wd_long;
  logic        wd_trip;
  logic [15:0] addr;
  logic        access;
  logic        addr_trip;

  modport ctrl (
    output wd_restart, wd_hold, wd_enable, wd_long, addr, access,
    input  wd_trip, addr_trip
  );
  modport wdog (
    input  wd_restart, wd_hold, wd_enable, wd_long,
    output wd_trip
  );
  modport chk (
    input  addr, access,
    output addr_trip
  );
endinterface
`default_nettype wire

// ---- hdl/addr_gap_check.sv ----
// Flags CPU accesses that fall into the illegal address gaps
`timescale 1ns/1ps
`default_nettype none
module addr_gap_check
  import reset_ctl_pkg::*;
(
  trip_if.chk tif
);

  // ==========================================================================
  // Gap decode
  function automatic logic in_gap(input logic [15:0] a);
    in_gap = ((a >= GAP1_LO) && (a <= GAP1_HI)) ||
             ((a >= GAP2_LO) && (a <= GAP2_HI));
  endfunction

  // Register areas lie outside both gaps, so holes there never trip
  assign tif.addr_trip = tif.access && in_gap(tif.addr);

endmodule
`default_nettype wire

// ---- hdl/watchdog_timer.sv ----
// Watchdog counter with short and long timeout
`timescale 1ns/1ps
`default_nettype none
module watchdog_timer
  import reset_ctl_pkg::*;
#(
  parameter int unsigned SHORT_CYCLES = WD_SHORT_CYCLES,
  parameter int unsigned LONG_CYCLES  = WD_LONG_CYCLES
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  trip_if.wdog      tif
);

  logic [WD_CNT_W-1:0] cnt_ff;
  logic [WD_CNT_W-1:0] nxt_cnt;
  logic [WD_CNT_W-1:0] limit;

  // Terminal count picked by the timeout select
  assign limit = tif.wd_long ? WD_CNT_W'(LONG_CYCLES - 1)
                             : WD_CNT_W'(SHORT_CYCLES - 1);
  // Disabled watchdog never trips
  assign tif.wd_trip = tif.wd_enable && !tif.wd_hold &&
                       (cnt_ff == limit);

  // ==========================================================================
  // Counter
  always_comb begin
    if (tif.wd_restart || tif.wd_hold || !tif.wd_enable) begin
      nxt_cnt = '0;
    end else if (cnt_ff == limit) begin
      nxt_cnt = '0;
    end else begin
      nxt_cnt = cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // Counter must also sit at zero, so enabling later starts a full period
  a_wd_gated: assert property (
    @(posedge sys_clk) disable iff (rst)
    !tif.wd_enable |-> !tif.wd_trip ##1 (cnt_ff == '0))
    else $error("watchdog tripped while disabled");

endmodule
`default_nettype wire

// ---- test/host_partner.sv ----
// Far-side model: CPU software bus cycles and serial debug host writes
`timescale 1ns/1ps
`default_nettype none
module host_partner
  import reset_ctl_pkg::*;
(
  input  wire logic        sys_clk,
  output logic      [15:0] cpu_addr,
  output logic             cpu_rd,
  output logic             cpu_wr,
  output logic      [7:0]  cpu_wdata,
  input  wire logic [7:0]  cpu_rdata,
  output logic             dbg_wr,
  output logic      [15:0] dbg_addr,
  output logic      [7:0]  dbg_wdata
);
  // ==========================================================================
  // Idle bus at time zero
  initial begin
    cpu_addr = 16'h0000;
    cpu_rd = 1'b0;
    cpu_wr = 1'b0;
    cpu_wdata = 8'h00;
    dbg_wr = 1'b0;
    dbg_addr = 16'h0000;
    dbg_wdata = 8'h00;
  end

  // ==========================================================================
  // Bus cycles: drive after a falling edge, hold over the taking edge
  // Released lines flip so nobody can lean on a stale value
  task automatic cpu_write(input logic [15:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    cpu_addr = a;
    cpu_wdata = d;
    cpu_wr = 1'b1;
    @(negedge sys_clk);
    cpu_wr = 1'b0;
    cpu_addr = ~a;
    cpu_wdata = ~d;
  endtask

  task automatic cpu_read(input logic [15:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    cpu_addr = a;
    cpu_rd = 1'b1;
    @(negedge sys_clk);
    d = cpu_rdata;
    cpu_rd = 1'b0;
    cpu_addr = ~a;
  endtask

  // Force register is only ever written from this port
  task automatic dbg_write(input logic [15:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    dbg_addr = a;
    dbg_wdata = d;
    dbg_wr = 1'b1;
    @(negedge sys_clk);
    dbg_wr = 1'b0;
    dbg_addr = ~a;
    dbg_wdata = ~d;
  endtask

  // Start-up code writes options 8'h02: watchdog off, short timeout, halt off, debug pin on
  task automatic sw_init();
    cpu_write(OPTIONS_ADDR, 8'h02);
  endtask
endmodule
`default_nettype wire

// ---- test/tb_reset_cause_and_system_options.sv ----
// Self-checking bench for the reset-cause and options block
`timescale 1ns/1ps
`default_nettype none
module tb_reset_cause_and_system_options
  import reset_ctl_pkg::*;
;
  localparam int         SHORT = 16;
  localparam int         LONG  = 64;
  localparam logic [7:0] DEF   = 8'hc2;
  logic        sys_clk, rst, reset_pin_n, opcode_unimpl, halt_exec;
  logic        enter_debug_exec, debug_mode_enable, clock_module_reset_req;
  logic        supply_low, supply_detect_enable, in_halt_mode;
  logic        supply_detect_reset_enable, supply_detect_in_halt_enable;
  logic        cpu_rd, cpu_wr, dbg_wr, system_reset, watchdog_enable;
  logic        watchdog_timeout_select, halt_mode_enable, debug_pin_enable;
  logic [15:0] cpu_addr, dbg_addr, a;
  logic [7:0]  cpu_wdata, cpu_rdata, dbg_wdata, reset_cause_status, rd, v;
  logic [31:0] seed;
  int          bad_count, check_count, cycles, rises, n;

  host_partner host (.sys_clk, .cpu_addr, .cpu_rd, .cpu_wr, .cpu_wdata,
    .cpu_rdata, .dbg_wr, .dbg_addr, .dbg_wdata);

  // Watchdog counts shortened so a timeout fits the run
  reset_cause_and_system_options #(.WD_SHORT(SHORT), .WD_LONG(LONG)) DUT (
    .sys_clk, .rst, .cpu_addr, .cpu_rd, .cpu_wr, .cpu_wdata, .cpu_rdata,
    .dbg_wr, .dbg_addr, .dbg_wdata, .reset_pin_n, .opcode_unimpl,
    .halt_exec, .enter_debug_exec, .debug_mode_enable,
    .clock_module_reset_req, .supply_low, .supply_detect_enable,
    .supply_detect_reset_enable, .supply_detect_in_halt_enable,
    .in_halt_mode, .system_reset, .reset_cause_status, .watchdog_enable,
    .watchdog_timeout_select, .halt_mode_enable, .debug_pin_enable);

  // ==========================================================================
  // Clock, reset counting, hang guard
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  always @(posedge system_reset) rises++;

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      summarize();
    end
  end

  // ==========================================================================
  // Comparison, expectations and verdict
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  function automatic logic [7:0] opt_of(input logic [7:0] w);
    return {w[7], w[6], w[5], 3'b000, w[1], 1'b0};
  endfunction

  function automatic logic [7:0] pins();
    return {watchdog_enable, watchdog_timeout_select, halt_mode_enable,
            3'b000, debug_pin_enable, 1'b0};
  endfunction

  function automatic logic [7:0] flag_of(input int s);
    case (s)
      0: return 8'h01 << B_PIN;
      4: return 8'h01 << B_CLK;
      5: return 8'h01 << B_LVD;
      default: return 8'h01 << B_OP;
    endcase
  endfunction

  // ==========================================================================
  // Stimulus helpers
  task automatic fire(input int s);
    @(negedge sys_clk);
    case (s)
      0: reset_pin_n = 1'b0;
      1: opcode_unimpl = 1'b1;
      2: halt_exec = 1'b1;
      3: enter_debug_exec = 1'b1;
      4: clock_module_reset_req = 1'b1;
      default: supply_low = 1'b1;
    endcase
    @(negedge sys_clk);
    reset_pin_n = 1'b1;
    opcode_unimpl = 1'b0;
    halt_exec = 1'b0;
    enter_debug_exec = 1'b0;
    clock_module_reset_req = 1'b0;
    supply_low = 1'b0;
  endtask

  // Bounded waits: reset must come, then end; flags and options checked
  task automatic settle(input logic [7:0] exp, input bit init);
    n = 0;
    while (system_reset !== 1'b1 && n < 300) begin
      @(negedge sys_clk);
      n++;
    end
    check("reset_seen", {7'h0, system_reset}, 8'h01);
    while (system_reset !== 1'b0 && n < 340) begin
      @(negedge sys_clk);
      n++;
    end
    check("cause", reset_cause_status, exp);
    check("opt_default", pins(), DEF);
    if (init) host.sw_init();
  endtask

  task automatic quiet(input int c, input int from);
    repeat (c) @(negedge sys_clk);
    check("no_reset", 8'(rises - from), 8'h00);
  endtask

  // A timeout measured from a restart by status write
  task automatic wd_time(input int lo, input int hi);
    host.cpu_write(STATUS_ADDR, 8'($random(seed)));
    n = 0;
    while (system_reset !== 1'b1 && n < 400) begin
      @(negedge sys_clk);
      n++;
    end
    check("wd_cycles", {7'h0, n >= lo && n <= hi}, 8'h01);
    settle(8'h01 << B_WD, 1'b0);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    seed = 32'haf0c9b6e;
    rst = 1'b1;
    reset_pin_n = 1'b1;
    opcode_unimpl = 1'b0;
    halt_exec = 1'b0;
    enter_debug_exec = 1'b0;
    debug_mode_enable = 1'b0;
    clock_module_reset_req = 1'b0;
    supply_low = 1'b0;
    supply_detect_enable = 1'b1;
    supply_detect_reset_enable = 1'b1;
    supply_detect_in_halt_enable = 1'b0;
    in_halt_mode = 1'b0;
    repeat (3) @(negedge sys_clk);
    rst = 1'b0;
    settle(8'h82, 1'b0);
    host.cpu_read(STATUS_ADDR, rd);
    check("status_rd", rd, 8'h82);
    host.cpu_write(STATUS_ADDR, 8'hff);
    host.cpu_read(STATUS_ADDR, rd);
    check("status_wr", rd, 8'h82);
    host.cpu_read(OPTIONS_ADDR, rd);
    check("opt_rd", rd, DEF);
    host.cpu_read(FORCE_ADDR, rd);
    check("force_rd", rd, 8'h00);
    v = 8'($random(seed)) & 8'h7f;
    host.cpu_write(OPTIONS_ADDR, v);
    host.cpu_write(OPTIONS_ADDR, ~v);
    host.cpu_read(OPTIONS_ADDR, rd);
    check("opt_once", rd, opt_of(v));
    check("opt_pins", pins(), opt_of(v));
    fire(5);
    settle(8'h82, 1'b1);
    for (int s = 0; s < 6; s++) begin
      fire(s);
      settle(flag_of(s), 1'b1);
    end
    // Gap edges plus one random address inside each gap
    for (int g = 0; g < 6; g++) begin
      case (g)
        0: a = GAP1_LO;
        1: a = GAP1_HI;
        2: a = GAP2_LO;
        3: a = GAP2_HI;
        4: a = GAP1_LO + 16'($unsigned($random(seed)) % 32'h0f80);
        default: a = GAP2_LO + 16'($unsigned($random(seed)) % 32'ha7d4);
      endcase
      host.cpu_read(a, rd);
      settle(8'h01 << B_AD, 1'b1);
    end
    // Accesses and events that must not reset
    n = rises;
    host.cpu_read(16'h087f, rd);
    host.cpu_read(16'h1803, rd);
    host.cpu_write(16'h182b, 8'h00);
    host.cpu_read(16'hc000, rd);
    host.cpu_write(FORCE_ADDR, 8'h01);
    host.dbg_write(FORCE_ADDR, 8'hfe);
    debug_mode_enable = 1'b1;
    fire(3);
    supply_detect_enable = 1'b0;
    fire(5);
    supply_detect_enable = 1'b1;
    supply_detect_reset_enable = 1'b0;
    fire(5);
    supply_detect_reset_enable = 1'b1;
    in_halt_mode = 1'b1;
    fire(5);
    quiet(20, n);
    in_halt_mode = 1'b0;
    debug_mode_enable = 1'b0;
    supply_detect_in_halt_enable = 1'b1;
    host.dbg_write(FORCE_ADDR, 8'h01);
    settle(8'h00, 1'b0);
    host.cpu_write(OPTIONS_ADDR, 8'h22);
    check("opt_halt", pins(), opt_of(8'h22));
    n = rises;
    fire(2);
    quiet(20, n);
    in_halt_mode = 1'b1;
    fire(5);
    settle(flag_of(5), 1'b0);
    in_halt_mode = 1'b0;
    // Watchdog: default long, then short, then kept alive by status writes
    wd_time(LONG - 3, LONG + 3);
    host.cpu_write(OPTIONS_ADDR, 8'h80);
    wd_time(SHORT - 3, SHORT + 3);
    host.cpu_write(OPTIONS_ADDR, 8'hc0);
    n = rises;
    repeat (4) begin
      host.cpu_write(STATUS_ADDR, 8'($random(seed)));
      repeat (LONG / 2) @(negedge sys_clk);
    end
    quiet(1, n);
    settle(8'h01 << B_WD, 1'b1);
    n = rises;
    // Longer than the long timeout, so a live watchdog would show up
    quiet(2 * LONG, n);
    summarize();
  end
endmodule
`default_nettype wire
